// file: hw/irb_pkg.sv
package irb_pkg;

  // register offsets, byte addresses on the register bus
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_EVT_CLEAR = 8'hA4;
  localparam logic [ADDR_W-1:0] OFS_MASK_SET = 8'hA8;
  localparam logic [ADDR_W-1:0] OFS_MASK_CLEAR = 8'hAC;
  localparam logic [ADDR_W-1:0] OFS_INIT_BW = 8'hB0;
  localparam logic [ADDR_W-1:0] OFS_INIT_CHAN_HI = 8'hB4;
  localparam logic [ADDR_W-1:0] OFS_INIT_CHAN_LO = 8'hB8;

  // field layouts
  localparam int CTX_N = 4;
  localparam int BW_W = 13;
  localparam int CHAN_W = 32;
  localparam int DATA_W = 32;
  localparam int RESET_SRC_N = 3;
  localparam int SRC_GLOBAL = 0;
  localparam int SRC_HOST = 1;
  localparam int SRC_BUS = 2;

  // reset values
  localparam logic [CTX_N-1:0] RST_MASK = 4'h0;
  localparam logic [BW_W-1:0] RST_INIT_BW = 13'h1333;
  localparam logic [CHAN_W-1:0] RST_INIT_CHAN = 32'hFFFFFFFF;

  // values handed to the bus management registers
  typedef struct packed {
    logic load;
    logic [BW_W-1:0] bandwidth;
    logic [CHAN_W-1:0] chanHi;
    logic [CHAN_W-1:0] chanLo;
  } irb_csr_load_s;

endpackage

// file: hw/irb_pin_sync.sv
`timescale 1ns/1ps
module irb_pin_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // asynchronous pins
  input wire logic [WIDTH-1:0] pinIn,
  // filtered level and its rising edge
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // three flops; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign next_level = (stage2 & stage3) | (level & (stage2 | stage3));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      level <= '0;
      rise <= '0;
    end else begin
      level <= next_level;
      rise <= next_level & ~level;
    end
  end

endmodule

// file: hw/irb_regs.sv
// Summary of operation
// RULE1 - four mask bits, each enabling the matching receive event into the summary
// RULE2 - reads at mask set or clear address return mask, no side effect
// RULE3 - ones written at set address set bits, at clear address clear them
// RULE4 - read of event clear address returns events ANDed with mask
// RULE5 - 13-bit bandwidth field, resets to 1333h, untouched by 1394 bus reset
// RULE6 - bandwidth register bits 31 to 13 always read zero
// RULE7 - global, host-bus or bus reset copies bandwidth field to its CSR
// RULE8 - channels upper register 32-bit, resets all ones, kept over bus reset
// RULE9 - global, host-bus or bus reset copies channels upper value to CSR
// RULE10 - channels lower register 32-bit, resets all ones, kept over bus reset
// RULE11 - global, host-bus or bus reset copies channels lower value to CSR
// RULE12 - mask bits 31 to 4 read zero; low mask bits need software setup
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module irb_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [irb_pkg::ADDR_W-1:0] paddr,
  input wire logic [irb_pkg::DATA_W-1:0] pwdata,
  output logic [irb_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive events from the event register
  input wire logic [irb_pkg::CTX_N-1:0] receiveContextEventBit,
  // reset pins, active high
  input wire logic globalResetInput,
  input wire logic hostBusResetInput,
  input wire logic busResetInput,
  // results
  output logic isoReceiveSummaryIrq,
  output logic [irb_pkg::CTX_N-1:0] rxIrqMask,
  output irb_pkg::irb_csr_load_s csrLoad
);
  import irb_pkg::*;

  logic [BW_W-1:0] initialBandwidthField;
  logic [CHAN_W-1:0] initialChannelsUpperField;
  logic [CHAN_W-1:0] initialChannelsLowerField;
  logic [RESET_SRC_N-1:0] resetLevel;
  logic [RESET_SRC_N-1:0] resetRise;
  logic startupLoad;
  logic setupPhase;
  logic accessDone;
  logic regWrite;
  logic copyTrigger;
  logic [DATA_W-1:0] readData;
  logic [CTX_N-1:0] maskedEvents;

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == OFS_EVT_CLEAR) || (a == OFS_MASK_SET) || (a == OFS_MASK_CLEAR) ||
               (a == OFS_INIT_BW) || (a == OFS_INIT_CHAN_HI) || (a == OFS_INIT_CHAN_LO);
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  irb_pin_sync #(
    .WIDTH(RESET_SRC_N)
  ) u_reset_sync (
    .clk(clk),
    .rstn(rstn),
    .pinIn({busResetInput, hostBusResetInput, globalResetInput}),
    .level(resetLevel),
    .rise(resetRise)
  );

  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & pready;
  assign regWrite = accessDone & pwrite & ~pslverr;
  // RULE7 copy on any reset source
  assign copyTrigger = startupLoad | (|resetRise);
  // RULE4 masked event view
  assign maskedEvents = receiveContextEventBit & rxIrqMask;

  always_comb begin
    readData = '0;
    if (hit(paddr, OFS_EVT_CLEAR)) begin
      readData[CTX_N-1:0] = maskedEvents;
    end else if (hit(paddr, OFS_MASK_SET) || hit(paddr, OFS_MASK_CLEAR)) begin
      // RULE2 both addresses read the mask
      readData[CTX_N-1:0] = rxIrqMask;
    end else if (hit(paddr, OFS_INIT_BW)) begin
      // RULE6 upper bits stay zero
      readData[BW_W-1:0] = initialBandwidthField;
    end else if (hit(paddr, OFS_INIT_CHAN_HI)) begin
      readData = initialChannelsUpperField;
    end else if (hit(paddr, OFS_INIT_CHAN_LO)) begin
      readData = initialChannelsLowerField;
    end
  end

  // bus answer, one access cycle after setup
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase & ~isMapped(paddr);
      if (setupPhase) begin
        prdata <= pwrite ? '0 : readData;
      end
    end
  end

  // RULE12 four-bit mask only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxIrqMask <= RST_MASK;
    end else if (regWrite && hit(paddr, OFS_MASK_SET)) begin
      // RULE3 write one to set
      rxIrqMask <= rxIrqMask | pwdata[CTX_N-1:0];
    end else if (regWrite && hit(paddr, OFS_MASK_CLEAR)) begin
      // RULE3 write one to clear
      rxIrqMask <= rxIrqMask & ~pwdata[CTX_N-1:0];
    end
  end

  // RULE1 summary gated per context
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      isoReceiveSummaryIrq <= 1'b0;
    end else begin
      isoReceiveSummaryIrq <= |maskedEvents;
    end
  end

  // RULE5 bandwidth field, system or software reset only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      initialBandwidthField <= RST_INIT_BW;
    end else if (resetRise[SRC_GLOBAL]) begin
      initialBandwidthField <= RST_INIT_BW;
    end else if (regWrite && hit(paddr, OFS_INIT_BW)) begin
      initialBandwidthField <= pwdata[BW_W-1:0];
    end
  end

  // RULE8 channels upper, kept over bus reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      initialChannelsUpperField <= RST_INIT_CHAN;
    end else if (resetRise[SRC_GLOBAL]) begin
      initialChannelsUpperField <= RST_INIT_CHAN;
    end else if (regWrite && hit(paddr, OFS_INIT_CHAN_HI)) begin
      initialChannelsUpperField <= pwdata;
    end
  end

  // RULE10 channels lower, kept over bus reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      initialChannelsLowerField <= RST_INIT_CHAN;
    end else if (resetRise[SRC_GLOBAL]) begin
      initialChannelsLowerField <= RST_INIT_CHAN;
    end else if (regWrite && hit(paddr, OFS_INIT_CHAN_LO)) begin
      initialChannelsLowerField <= pwdata;
    end
  end

  // one load after the system reset releases
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      startupLoad <= 1'b1;
    end else begin
      startupLoad <= 1'b0;
    end
  end

  // RULE9 RULE11 copy to bus management registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      csrLoad <= '0;
    end else begin
      csrLoad.load <= copyTrigger;
      if (copyTrigger && resetRise[SRC_GLOBAL]) begin
        csrLoad.bandwidth <= RST_INIT_BW;
        csrLoad.chanHi <= RST_INIT_CHAN;
        csrLoad.chanLo <= RST_INIT_CHAN;
      end else if (copyTrigger) begin
        csrLoad.bandwidth <= initialBandwidthField;
        csrLoad.chanHi <= initialChannelsUpperField;
        csrLoad.chanLo <= initialChannelsLowerField;
      end
    end
  end

  chk_summary_gate: assert property ( // RULE1
    @(posedge clk) disable iff (!rstn)
    1'b1 |=> isoReceiveSummaryIrq == |($past(receiveContextEventBit) & $past(rxIrqMask)))
    else $error("summary interrupt does not follow masked events");

  chk_read_no_effect: assert property ( // RULE2
    @(posedge clk) disable iff (!rstn)
    accessDone && !pwrite |=> rxIrqMask == $past(rxIrqMask))
    else $error("mask changed on a read");

  chk_mask_set: assert property ( // RULE3
    @(posedge clk) disable iff (!rstn)
    regWrite && hit(paddr, OFS_MASK_SET) |=>
      rxIrqMask == ($past(rxIrqMask) | $past(pwdata[CTX_N-1:0])))
    else $error("mask set write wrong");

  chk_mask_clear: assert property ( // RULE3
    @(posedge clk) disable iff (!rstn)
    regWrite && hit(paddr, OFS_MASK_CLEAR) |=>
      rxIrqMask == ($past(rxIrqMask) & ~$past(pwdata[CTX_N-1:0])))
    else $error("mask clear write wrong");

  chk_event_read: assert property ( // RULE4
    @(posedge clk) disable iff (!rstn)
    setupPhase && !pwrite && hit(paddr, OFS_EVT_CLEAR) |=>
      pready && prdata == {28'h0000000, $past(maskedEvents)})
    else $error("masked event read wrong");

  chk_bw_default: assert property ( // RULE5
    @(posedge clk) disable iff (!rstn)
    resetRise[SRC_GLOBAL] |=> initialBandwidthField == RST_INIT_BW)
    else $error("bandwidth field not reset by global reset");

  chk_bw_upper_zero: assert property ( // RULE6
    @(posedge clk) disable iff (!rstn)
    setupPhase && !pwrite && hit(paddr, OFS_INIT_BW) |=> prdata[DATA_W-1:BW_W] == '0)
    else $error("bandwidth upper bits not zero");

  chk_bw_copy: assert property ( // RULE7
    @(posedge clk) disable iff (!rstn)
    resetRise[SRC_BUS] && !resetRise[SRC_GLOBAL] |=>
      csrLoad.load && csrLoad.bandwidth == $past(initialBandwidthField))
    else $error("bandwidth not copied on bus reset");

  chk_hi_kept: assert property ( // RULE8
    @(posedge clk) disable iff (!rstn)
    resetRise[SRC_BUS] && !resetRise[SRC_GLOBAL] && !regWrite |=>
      $stable(initialChannelsUpperField))
    else $error("channels upper changed by bus reset");

  chk_hi_copy: assert property ( // RULE9
    @(posedge clk) disable iff (!rstn)
    resetRise[SRC_HOST] && !resetRise[SRC_GLOBAL] |=>
      csrLoad.load && csrLoad.chanHi == $past(initialChannelsUpperField))
    else $error("channels upper not copied on host-bus reset");

  chk_lo_kept: assert property ( // RULE10
    @(posedge clk) disable iff (!rstn)
    resetRise[SRC_BUS] && !resetRise[SRC_GLOBAL] && !regWrite |=>
      $stable(initialChannelsLowerField))
    else $error("channels lower changed by bus reset");

  chk_lo_copy: assert property ( // RULE11
    @(posedge clk) disable iff (!rstn)
    resetRise[SRC_GLOBAL] |=> csrLoad.load && csrLoad.chanLo == RST_INIT_CHAN)
    else $error("channels lower not copied on global reset");

  chk_mask_upper_zero: assert property ( // RULE12
    @(posedge clk) disable iff (!rstn)
    setupPhase && !pwrite && hit(paddr, OFS_MASK_SET) |=>
      prdata[DATA_W-1:CTX_N] == '0 && prdata[CTX_N-1:0] == $past(rxIrqMask))
    else $error("mask upper bits not zero");

endmodule

// file: sim/iso_rx_mask_and_bus_mgmt_init_tb_top.sv
`timescale 1ns/1ps
module iso_rx_mask_and_bus_mgmt_init_tb_top;
  import irb_pkg::*;

  typedef struct {
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] evt;
    logic [31:0] exp;
    logic err;
  } irb_row_s;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [CTX_N-1:0] evt = 4'h0;
  logic [2:0] rstPins = 3'h0;
  logic isoReceiveSummaryIrq;
  logic [CTX_N-1:0] rxIrqMask;
  irb_csr_load_s csrLoad;
  irb_csr_load_s lastLoad;
  int loadCnt = 0;
  int bad_count = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic er;

  // ordinary register traffic: write, address, data, events, expected read, expected error
  irb_row_s rows [0:24] = '{
    '{1'b0, 8'hB0, 32'h0, 4'h0, 32'h00001333, 1'b0},
    '{1'b0, 8'hB4, 32'h0, 4'h0, 32'hFFFFFFFF, 1'b0},
    '{1'b0, 8'hB8, 32'h0, 4'h0, 32'hFFFFFFFF, 1'b0},
    '{1'b0, 8'hA8, 32'h0, 4'h0, 32'h0, 1'b0},
    '{1'b0, 8'hAC, 32'h0, 4'h0, 32'h0, 1'b0},
    '{1'b1, 8'hB0, 32'hFFFFFFFF, 4'h0, 32'h0, 1'b0},
    '{1'b0, 8'hB0, 32'h0, 4'h0, 32'h00001FFF, 1'b0},
    '{1'b1, 8'hB4, 32'h12345678, 4'h0, 32'h0, 1'b0},
    '{1'b0, 8'hB4, 32'h0, 4'h0, 32'h12345678, 1'b0},
    '{1'b1, 8'hB8, 32'h9ABCDEF0, 4'h0, 32'h0, 1'b0},
    '{1'b0, 8'hB8, 32'h0, 4'h0, 32'h9ABCDEF0, 1'b0},
    '{1'b1, 8'hA8, 32'hFFFFFFF5, 4'h0, 32'h0, 1'b0},
    '{1'b0, 8'hAC, 32'h0, 4'h0, 32'h00000005, 1'b0},
    '{1'b1, 8'hAC, 32'h00000001, 4'h0, 32'h0, 1'b0},
    '{1'b0, 8'hA8, 32'h0, 4'h0, 32'h00000004, 1'b0},
    '{1'b1, 8'hA8, 32'h0, 4'h0, 32'h0, 1'b0},
    '{1'b0, 8'hAC, 32'h0, 4'h0, 32'h00000004, 1'b0},
    '{1'b0, 8'hA4, 32'h0, 4'hF, 32'h00000004, 1'b0},
    '{1'b1, 8'hA8, 32'h0000000A, 4'hF, 32'h0, 1'b0},
    '{1'b0, 8'hA8, 32'h0, 4'hF, 32'h0000000E, 1'b0},
    '{1'b0, 8'hA4, 32'h0, 4'h3, 32'h00000002, 1'b0},
    '{1'b1, 8'hA4, 32'hFFFFFFFF, 4'h3, 32'h0, 1'b0},
    '{1'b0, 8'hA8, 32'h0, 4'h3, 32'h0000000E, 1'b0},
    '{1'b1, 8'hA0, 32'h1, 4'h3, 32'h0, 1'b1},
    '{1'b0, 8'hFC, 32'h0, 4'h3, 32'h0, 1'b1}};

  irb_regs i_irb_regs (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .receiveContextEventBit(evt), .globalResetInput(rstPins[0]),
    .hostBusResetInput(rstPins[1]), .busResetInput(rstPins[2]),
    .isoReceiveSummaryIrq(isoReceiveSummaryIrq), .rxIrqMask(rxIrqMask), .csrLoad(csrLoad));

  always #5 clk = ~clk;

  // record every copy pulse towards the bus management registers
  always @(posedge clk) begin
    if (csrLoad.load === 1'b1) begin
      loadCnt <= loadCnt + 1;
      lastLoad <= csrLoad;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rst_pulse(input int idx);
    int n;
    n = loadCnt;
    @(posedge clk);
    rstPins[idx] <= 1'b1;
    repeat (4) @(posedge clk);
    rstPins[idx] <= 1'b0;
    for (int k = 0; k < 12 && loadCnt == n; k++) @(posedge clk);
    check(loadCnt - n, 32'h1); // copy pulse
    repeat (3) @(posedge clk);
  endtask

  task automatic check_load(input logic [31:0] bw, input logic [31:0] hi, input logic [31:0] lo);
    check({19'h0, lastLoad.bandwidth}, bw); // bandwidth copy
    check(lastLoad.chanHi, hi); // upper copy
    check(lastLoad.chanLo, lo); // lower copy
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    finish_test();
  end

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    check(loadCnt, 32'h1); // startup copy
    check_load(32'h1333, 32'hFFFFFFFF, 32'hFFFFFFFF);
    foreach (rows[i]) begin
      evt <= rows[i].evt;
      apb(rows[i].wr, rows[i].addr, rows[i].wdata);
      if (!rows[i].wr) check(rd, rows[i].exp);
      check({31'h0, er}, {31'h0, rows[i].err}); // error response
    end
    check({28'h0, rxIrqMask}, 32'hE); // mask port
    repeat (3) @(posedge clk);
    check({31'h0, isoReceiveSummaryIrq}, 32'h1); // masked event
    evt <= 4'h1;
    repeat (3) @(posedge clk);
    check({31'h0, isoReceiveSummaryIrq}, 32'h0); // unmasked bit
    // 1394 bus reset then host-bus reset: copy current values, keep registers
    for (int p = 2; p > 0; p--) begin
      rst_pulse(p);
      check_load(32'h1FFF, 32'h12345678, 32'h9ABCDEF0);
      apb(1'b0, 8'hB0, 32'h0);
      check(rd, 32'h00001FFF); // kept over bus reset
      apb(1'b0, 8'hB4, 32'h0);
      check(rd, 32'h12345678); // kept over bus reset
      apb(1'b0, 8'hB8, 32'h0);
      check(rd, 32'h9ABCDEF0); // kept over bus reset
    end
    // software reset: defaults return and are copied, mask left alone
    rst_pulse(0);
    check_load(32'h1333, 32'hFFFFFFFF, 32'hFFFFFFFF);
    apb(1'b0, 8'hB0, 32'h0);
    check(rd, 32'h00001333); // software reset value
    apb(1'b0, 8'hB8, 32'h0);
    check(rd, 32'hFFFFFFFF); // software reset value
    apb(1'b0, 8'hAC, 32'h0);
    check(rd, 32'h0000000E); // mask untouched
    apb(1'b0, 8'hB4, 32'h0);
    check(rd, 32'hFFFFFFFF); // software reset value
    // system reset mid-run: mask cleared, one more startup copy
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    check({28'h0, rxIrqMask}, 32'h0); // mask reset value
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    check(loadCnt, 32'h5); // startup copy again
    check_load(32'h1333, 32'hFFFFFFFF, 32'hFFFFFFFF);
    apb(1'b0, 8'hAC, 32'h0);
    check(rd, 32'h0); // mask after system reset
    finish_test();
  end
endmodule
